// >>> inc/incl_pkg.sv
// Purpose: Shared constants for the tilt sensor digital readout
// Assumes: 125 MHz system clock, single clock domain
// Notes:   Times are kept in their own units; cycle counts derive from them
package incl_pkg;

  // Clock rate
  localparam int CLK_MHZ = 125;

  // Serial commands (8 bits, MSB first)
  localparam logic [7:0] MEASURE_MODE_CMD = 8'h00;
  localparam logic [7:0] TEMP_READ_CMD    = 8'h08;
  localparam logic [7:0] X_SELF_TEST_CMD  = 8'h0e;
  localparam logic [7:0] X_ACCEL_READ_CMD = 8'h10;
  localparam int         CMD_BITS         = 8;

  // Acceleration word format
  localparam int         ACC_W      = 11;
  localparam int         TEMP_W     = 8;
  localparam int         ACC_ZERO   = 1024;
  localparam int         ACC_WIN_LO = 102;
  localparam int         ACC_WIN_HI = 1945;
  localparam logic [10:0] ACC_FULL  = 11'h7ff;
  localparam logic [10:0] ACC_FAULT = 11'h000;
  localparam int         SENS_NARROW = 1638;
  localparam int         SENS_WIDE   = 819;
  localparam int         MILLI       = 1000;

  // Temperature transfer: count = 197 - 1.083 * degC
  localparam int TEMP_OFFS        = 197;
  localparam int TEMP_SLOPE_MILLI = 1083;
  localparam int TEMP_MAX         = 255;

  // Result reload period
  localparam int LOAD_PERIOD_US = 150;
  localparam int LOAD_CYC       = LOAD_PERIOD_US * CLK_MHZ;

  // Self-test timing (typical)
  localparam int SAT_DELAY_MS = 25;
  localparam int RECOVER_MS   = 30;
  localparam int SAT_CYC      = SAT_DELAY_MS * CLK_MHZ * 1000;
  localparam int REC_CYC      = RECOVER_MS * CLK_MHZ * 1000;
  localparam int TIMER_W      = 22;

  // Calibration memory: data byte plus even parity bit
  localparam int CAL_WORDS = 8;
  localparam int CAL_AW    = 3;
  localparam int CAL_DW    = 9;

  // Reset values
  localparam logic [10:0] ACC_RESET  = 11'h400;
  localparam logic [7:0]  TEMP_RESET = 8'h00;

  typedef enum {CAL_SCAN, CAL_RELOAD, CAL_RECHECK, CAL_FAIL} incl_cal_t;
  typedef enum {ST_OFF, ST_RAMP, ST_HOLD, ST_RECOVER} incl_st_t;

endpackage : incl_pkg

// >>> logic/incl_cal_mem.sv
// Purpose: Calibration word store with one write and one registered read port
// Assumes: Synchronous read, data valid the cycle after the address
// Notes:   Content is undefined until trimmed or reloaded
module incl_cal_mem (
  input  wire logic                        clk_sys,  // System clock
  input  wire logic                        wrEn,     // Write strobe
  input  wire logic [incl_pkg::CAL_AW-1:0] wrAddr,   // Write address
  input  wire logic [incl_pkg::CAL_DW-1:0] wrData,   // Write data with parity
  input  wire logic [incl_pkg::CAL_AW-1:0] rdAddr,   // Read address
  output logic      [incl_pkg::CAL_DW-1:0] rdData    // Registered read data
);
  import incl_pkg::*;

  logic [CAL_DW-1:0] mem [CAL_WORDS];

  // Write port
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys) begin
    rdData <= mem[rdAddr];
  end

endmodule : incl_cal_mem

// >>> logic/incl_readout.sv
// Purpose: Digital readout of a single-axis tilt sensor with serial slave port
// Assumes: Serial pins sampled synchronously to clk_sys; clk_sys far above serial clock
// Notes:   Calibration parity scanning, fault forcing and self-test sequencing
// Notes on behaviour
// - Acceleration is 11-bit unsigned, MSB first
// - Zero tilt reads mid-scale 1024
// - Sensitivity 1638 or 819 counts per g
// - Healthy codes stay within 102 to 1945
// - Interconnect failure forces output to ground extreme
// - Parity error reloads calibration from nonvolatile memory
// - Repeated parity error holds output below 102
// - Self-test drives output to maximum unless interconnect or calibration failure forces it to ground
// - Self-test from pin or serial command
// - Self-test command latches until measure command
// - Pin high activates self-test
// - Saturate after 25 ms, recover 30 ms after
// - Output returns to pre-test value afterwards
// - Temperature read as unsigned 8-bit count
// - Temperature count is 197 minus 1.083 per degree
// - Command codes for self-test, accel and temperature reads
// - All-zero command selects measure mode, default
// - Results reload every 150 us unless selected
module incl_readout #(
  parameter int LOAD_CYC_P = incl_pkg::LOAD_CYC,  // Result reload period in cycles
  parameter int SAT_CYC_P  = incl_pkg::SAT_CYC,   // Self-test saturation delay in cycles
  parameter int REC_CYC_P  = incl_pkg::REC_CYC    // Self-test recovery time in cycles
) (
  input  wire logic                        clk_sys,          // System clock
  input  wire logic                        reset_n,          // Synchronous reset, active low
  input  wire logic                        spiSclk,          // Serial clock from host
  input  wire logic                        spiMosi,          // Serial data in
  input  wire logic                        chipSelectN,      // Chip select, active low
  output logic                             spiMiso,          // Serial data out
  output logic                             spiMisoOe,        // Drive enable for serial data out
  input  wire logic                        selfTestPin,      // Self-test request pin, active high
  input  wire logic                        rangeWide,        // 1 selects wide-range sensitivity
  input  wire logic signed [15:0]          accelMilliG,      // Converted acceleration in mg
  input  wire logic signed [7:0]           tempCelsius,      // Sensor die temperature in degC
  input  wire logic                        interconnectFail, // Sensing element link failure
  input  wire logic                        trimWrEn,         // Calibration trim write strobe
  input  wire logic [incl_pkg::CAL_AW-1:0] trimWrAddr,       // Calibration trim address
  input  wire logic [incl_pkg::CAL_DW-1:0] trimWrData,       // Calibration trim data with parity
  output logic      [incl_pkg::CAL_AW-1:0] nvmAddr,          // Nonvolatile memory read address
  input  wire logic [incl_pkg::CAL_DW-1:0] nvmRdData,        // Nonvolatile data, one cycle after addr
  output logic                             calFault,         // Calibration memory failed after reload
  output logic                             selfTestOn        // Self-test request active
);
  import incl_pkg::*;

  // Clamp a signed value into [lo,hi]; used for acceleration and temperature
  function automatic logic [10:0] clip(input logic signed [27:0] v,
                                       input logic signed [27:0] lo,
                                       input logic signed [27:0] hi);
    logic signed [27:0] t;
    t = v;
    if (t < lo) t = lo;
    if (t > hi) t = hi;
    return t[10:0];
  endfunction : clip

  // ---------------- Declarations ----------------
  logic                 sclkPrev_r;
  logic [3:0]           bitCnt_r;
  logic [CMD_BITS-1:0]  cmdShift_r;
  logic [ACC_W-1:0]     txShift_r;
  logic                 sending_r;
  logic                 stLatch_r;
  logic [ACC_W-1:0]     accelReg_r;
  logic [TEMP_W-1:0]    tempReg_r;
  logic [14:0]          loadCnt_r;
  incl_st_t             stState_r;
  logic [TIMER_W-1:0]   stCnt_r;
  incl_cal_t            calState_r;
  logic [CAL_AW-1:0]    scanAddr_r;
  logic [CAL_AW-1:0]    chkAddr_r;
  logic                 rdValid_r;
  logic                 relValid_r;
  logic [CAL_AW-1:0]    relAddr_r;
  logic [CAL_DW-1:0]    calRdData;

  // ---------------- Serial decode ----------------
  wire                  sclkRise  = spiSclk & ~sclkPrev_r;
  wire                  sclkFall  = ~spiSclk & sclkPrev_r;
  wire                  cmdBit    = sclkRise && (bitCnt_r < 4'(CMD_BITS));
  wire                  cmdDone   = cmdBit && (bitCnt_r == 4'(CMD_BITS - 1));
  wire [CMD_BITS-1:0]   cmdNxt    = {cmdShift_r[CMD_BITS-2:0], spiMosi};
  wire                  isAccRd   = cmdDone && (cmdNxt == X_ACCEL_READ_CMD);
  wire                  isTempRd  = cmdDone && (cmdNxt == TEMP_READ_CMD);
  wire                  isStCmd   = cmdDone && (cmdNxt == X_SELF_TEST_CMD);
  wire                  isMeasCmd = cmdDone && (cmdNxt == MEASURE_MODE_CMD);

  // ---------------- Result formatting ----------------
  wire signed [27:0]    sens      = rangeWide ? 28'(SENS_WIDE) : 28'(SENS_NARROW);
  wire signed [27:0]    accProd   = 28'(accelMilliG) * sens;
  wire signed [27:0]    accCode   = accProd / 28'sd1000 + 28'(ACC_ZERO);
  wire [ACC_W-1:0]      accClip   = clip(accCode, 28'(ACC_WIN_LO), 28'(ACC_WIN_HI));
  wire signed [27:0]    tmpProd   = 28'(tempCelsius) * 28'(TEMP_SLOPE_MILLI);
  wire signed [27:0]    tmpCode   = 28'(TEMP_OFFS) - tmpProd / 28'(MILLI);
  wire [ACC_W-1:0]      tmpClip   = clip(tmpCode, 28'sd0, 28'(TEMP_MAX));
  wire                  stSat     = (stState_r == ST_HOLD) || (stState_r == ST_RECOVER);
  wire                  calBad    = (calState_r == CAL_FAIL);
  wire [ACC_W-1:0]      accSel    = calBad           ? ACC_FAULT :
                                    interconnectFail ? ACC_FAULT :
                                    stSat            ? ACC_FULL  :
                                    accClip;
  wire                  loadTick  = (loadCnt_r == 15'(LOAD_CYC_P - 1));
  wire                  loadEn    = loadTick && chipSelectN;

  // ---------------- Self-test request ----------------
  wire                  stReq     = selfTestPin | stLatch_r;
  wire                  satDone   = (stCnt_r == TIMER_W'(SAT_CYC_P - 1));
  wire                  recDone   = (stCnt_r == TIMER_W'(REC_CYC_P - 1));

  // ---------------- Calibration check ----------------
  wire                  scanning  = (calState_r == CAL_SCAN) || (calState_r == CAL_RECHECK);
  wire                  parityErr = rdValid_r && (^calRdData);
  wire                  chkLast   = rdValid_r && (chkAddr_r == CAL_AW'(CAL_WORDS - 1));
  wire                  relLast   = relValid_r && (relAddr_r == CAL_AW'(CAL_WORDS - 1));
  wire                  memWrEn   = relValid_r | (trimWrEn & ~relValid_r);
  wire [CAL_AW-1:0]     memWrAddr = relValid_r ? relAddr_r : trimWrAddr;
  wire [CAL_DW-1:0]     memWrData = relValid_r ? nvmRdData : trimWrData;

  incl_cal_mem u_calMem (
    .clk_sys (clk_sys),
    .wrEn    (memWrEn),
    .wrAddr  (memWrAddr),
    .wrData  (memWrData),
    .rdAddr  (scanAddr_r),
    .rdData  (calRdData)
  );

  // Serial shift engine: command in on rising edge, data out on falling edge
  always_ff @(posedge clk_sys) begin
    sclkPrev_r <= spiSclk;
    if (!reset_n || chipSelectN) begin
      bitCnt_r   <= 4'h0;
      cmdShift_r <= 8'h00;
      txShift_r  <= 11'h000;
      sending_r  <= 1'b0;
      spiMiso    <= 1'b0;
      spiMisoOe  <= 1'b0;
    end else begin
      if (cmdBit) begin
        cmdShift_r <= cmdNxt;
        bitCnt_r   <= bitCnt_r + 4'h1;
      end
      if (isAccRd) begin
        txShift_r <= accelReg_r;
        sending_r <= 1'b1;
      end else if (isTempRd) begin
        txShift_r <= {tempReg_r, 3'h0};
        sending_r <= 1'b1;
      end else if (sclkFall && sending_r) begin
        spiMiso   <= txShift_r[ACC_W-1];
        spiMisoOe <= 1'b1;
        txShift_r <= {txShift_r[ACC_W-2:0], 1'b0};
      end
    end
  end

  // Serial self-test latch; measure mode is the power-up default
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stLatch_r <= 1'b0;
    end else if (isStCmd) begin
      stLatch_r <= 1'b1;
    end else if (isMeasCmd) begin
      stLatch_r <= 1'b0;
    end
  end

  // Result registers reload on the period tick while deselected
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      loadCnt_r  <= 15'h0000;
      accelReg_r <= ACC_RESET;
      tempReg_r  <= TEMP_RESET;
    end else begin
      loadCnt_r <= loadTick ? 15'h0000 : loadCnt_r + 15'h0001;
      if (loadEn) begin
        accelReg_r <= accSel;
        tempReg_r  <= tmpClip[TEMP_W-1:0];
      end
    end
  end

  // Self-test sequencing: saturation delay, hold, recovery
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stState_r  <= ST_OFF;
      stCnt_r    <= '0;
      selfTestOn <= 1'b0;
    end else begin
      selfTestOn <= stReq;
      stCnt_r    <= stCnt_r + TIMER_W'(1);
      case (stState_r)
        ST_OFF: begin
          stCnt_r <= '0;
          if (stReq) stState_r <= ST_RAMP;
        end
        ST_RAMP: begin
          if (!stReq) begin
            stState_r <= ST_RECOVER;
            stCnt_r   <= '0;
          end else if (satDone) begin
            stState_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          stCnt_r <= '0;
          if (!stReq) stState_r <= ST_RECOVER;
        end
        ST_RECOVER: begin
          if (stReq) begin
            stState_r <= ST_RAMP;
            stCnt_r   <= '0;
          end else if (recDone) begin
            stState_r <= ST_OFF;
          end
        end
        default: stState_r <= ST_OFF;
      endcase
    end
  end

  // Continuous parity scan, reload on error, sticky failure after recheck
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      calState_r <= CAL_SCAN;
      scanAddr_r <= '0;
      chkAddr_r  <= '0;
      rdValid_r  <= 1'b0;
      relValid_r <= 1'b0;
      relAddr_r  <= '0;
      nvmAddr    <= '0;
      calFault   <= 1'b0;
    end else begin
      calFault   <= calBad;
      chkAddr_r  <= scanAddr_r;
      rdValid_r  <= scanning && !parityErr && !chkLast;
      relValid_r <= 1'b0;
      relAddr_r  <= nvmAddr;
      case (calState_r)
        CAL_SCAN: begin
          scanAddr_r <= scanAddr_r + CAL_AW'(1);
          if (chkLast) begin
            scanAddr_r <= '0;
          end
          if (parityErr) begin
            calState_r <= CAL_RELOAD;
            nvmAddr    <= '0;
          end
        end
        CAL_RELOAD: begin
          relValid_r <= 1'b1;
          nvmAddr    <= nvmAddr + CAL_AW'(1);
          if (relValid_r && relLast) begin
            relValid_r <= 1'b0;
            calState_r <= CAL_RECHECK;
            scanAddr_r <= '0;
          end
        end
        CAL_RECHECK: begin
          scanAddr_r <= scanAddr_r + CAL_AW'(1);
          if (parityErr) begin
            calState_r <= CAL_FAIL;
          end else if (chkLast) begin
            calState_r <= CAL_SCAN;
            scanAddr_r <= '0;
          end
        end
        CAL_FAIL: begin
          scanAddr_r <= '0;  // Held until reset
        end
        default: calState_r <= CAL_SCAN;
      endcase
    end
  end

endmodule : incl_readout

// >>> verif/incl_readout_monitor.sv
// Purpose: Port-level checks for the tilt sensor readout
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every readout instance
module incl_readout_monitor (
  input wire logic                        clk_sys,     // Clock
  input wire logic                        reset_n,     // Reset, active low
  input wire logic                        spiSclk,     // Serial clock
  input wire logic                        chipSelectN, // Select, active low
  input wire logic                        spiMiso,     // Serial out
  input wire logic                        spiMisoOe,   // Out enable
  input wire logic                        selfTestPin, // Self-test pin
  input wire logic [incl_pkg::CAL_AW-1:0] nvmAddr,     // NVM address
  input wire logic                        calFault,    // Calibration failed
  input wire logic                        selfTestOn   // Self-test active
);
  timeunit 1ns;
  timeprecision 1ps;
  import incl_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Reset leaves all outputs quiet
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !spiMisoOe && !calFault && !selfTestOn)
    else $error("outputs not quiet after reset");
  // Pin request reaches the self-test flag next cycle
  a_pin_selftest: assert property (selfTestPin |=> selfTestOn)
    else $error("pin did not start self-test");
  // Flag drops only when the pin was low
  a_st_drop_ok: assert property ($fell(selfTestOn) |-> !$past(selfTestPin))
    else $error("self-test dropped while pin high");
  // Link is released from the second deselected cycle on
  a_oe_release: assert property (chipSelectN && $past(chipSelectN) |-> !spiMisoOe)
    else $error("data driven while deselected");
  // Driving starts only inside a frame and after a clock fall
  a_oe_start: assert property ($rose(spiMisoOe) |-> !chipSelectN && !$past(chipSelectN) && !$past(spiSclk))
    else $error("data out began out of frame");
  // Data bit holds while the serial clock is high
  a_miso_hold: assert property (spiSclk && $past(spiSclk) && spiMisoOe && $past(spiMisoOe) |-> $stable(spiMiso))
    else $error("data out moved during clock high");
  // Reload walks addresses upward one step at a time
  a_nvm_walk: assert property ($changed(nvmAddr) && nvmAddr != '0 |-> nvmAddr == $past(nvmAddr) + 1)
    else $error("reload address skipped");
  // Calibration fault stays until reset
  a_cal_sticky: assert property (calFault |=> calFault [*3])
    else $error("calibration fault cleared");
  c_read: cover property ($rose(spiMisoOe));
  c_fault: cover property ($rose(calFault));
  c_stest: cover property ($rose(selfTestOn));
endmodule : incl_readout_monitor

bind incl_readout incl_readout_monitor u_incl_readout_monitor (
  .clk_sys(clk_sys), .reset_n(reset_n), .spiSclk(spiSclk), .chipSelectN(chipSelectN), .spiMiso(spiMiso),
  .spiMisoOe(spiMisoOe), .selfTestPin(selfTestPin), .nvmAddr(nvmAddr), .calFault(calFault),
  .selfTestOn(selfTestOn));

// >>> verif/incl_spi_host.sv
// Purpose: Microcontroller model, serial link master
// Assumes: Clock half period of four system cycles
// Notes:   Samples data on the rising serial clock
module incl_spi_host (
  input  wire logic clk_sys,     // System clock
  input  wire logic spiMiso,     // Data from device
  input  wire logic spiMisoOe,   // Device drives data
  output logic      spiSclk,     // Serial clock, idle low
  output logic      spiMosi,     // Data to device
  output logic      chipSelectN  // Select, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastMiso;
  logic misoLine;
  logic sawOe;
  // A released line shows the inverse of the last bit
  assign misoLine = spiMisoOe ? spiMiso : ~lastMiso;
  // Track driven bits and any drive at all
  always @(posedge clk_sys) begin
    if (spiMisoOe) begin
      lastMiso <= spiMiso;
      sawOe <= 1'b1;
    end
  end
  initial begin
    spiSclk = 1'b0;
    spiMosi = 1'b0;
    chipSelectN = 1'b1;
    lastMiso = 1'b0;
    sawOe = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask : half
  // One frame: command then n data clocks, clock still outside frames
  // Select stays high a while after each frame so the device clears its bit count
  task automatic xfer(input logic [7:0] cmd, input int n, output logic [15:0] rx);
    rx = '0;
    chipSelectN = 1'b0;
    half();
    for (int i = 0; i < 8 + n; i++) begin
      spiMosi = (i < 8) ? cmd[7-i] : 1'b0;
      half();
      spiSclk = 1'b1;
      if (i >= 8) rx = {rx[14:0], misoLine};
      half();
      spiSclk = 1'b0;
    end
    half();
    chipSelectN = 1'b1;
    half();
  endtask : xfer
endmodule : incl_spi_host

// >>> verif/incl_readout_tb_top.sv
// Purpose: Self-checking bench for the tilt sensor readout
// Assumes: Shortened reload and self-test counts
// Notes:   Inputs change on the falling clock edge
module incl_readout_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import incl_pkg::*;
  localparam int LOAD = 20;
  localparam int SAT  = 50;
  localparam int REC  = 60;
  logic clk_sys, reset_n, spiSclk, spiMosi, chipSelectN, spiMiso, spiMisoOe, selfTestPin, rangeWide;
  logic interconnectFail, trimWrEn, calFault, selfTestOn, sawReload;
  logic signed [15:0] accelMilliG;
  logic signed [7:0]  tempCelsius;
  logic [CAL_AW-1:0]  trimWrAddr, nvmAddr;
  logic [CAL_DW-1:0]  trimWrData, nvmRdData;
  logic [CAL_DW-1:0]  nvmImage [CAL_WORDS];
  logic [15:0]        rx;
  int n_errors = 0;
  int checks_done = 0;
  incl_readout #(.LOAD_CYC_P(LOAD), .SAT_CYC_P(SAT), .REC_CYC_P(REC)) u_incl_readout (
    .clk_sys(clk_sys), .reset_n(reset_n), .spiSclk(spiSclk), .spiMosi(spiMosi), .chipSelectN(chipSelectN),
    .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .selfTestPin(selfTestPin), .rangeWide(rangeWide),
    .accelMilliG(accelMilliG), .tempCelsius(tempCelsius), .interconnectFail(interconnectFail),
    .trimWrEn(trimWrEn), .trimWrAddr(trimWrAddr), .trimWrData(trimWrData), .nvmAddr(nvmAddr),
    .nvmRdData(nvmRdData), .calFault(calFault), .selfTestOn(selfTestOn));
  incl_spi_host u_incl_spi_host (.clk_sys(clk_sys), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .chipSelectN(chipSelectN));
  always #4 clk_sys = ~clk_sys;
  // NVM answers one cycle after the address; note any reload walk
  always @(posedge clk_sys) begin
    nvmRdData <= nvmImage[nvmAddr];
    if (nvmAddr != '0) sawReload <= 1'b1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // Expected code: mid-scale plus truncated scaled input, kept in the window
  function automatic logic [15:0] accExp(input int mg, input logic wide);
    int v;
    v = ACC_ZERO + (mg * (wide ? SENS_WIDE : SENS_NARROW)) / MILLI;
    v = (v < ACC_WIN_LO) ? ACC_WIN_LO : (v > ACC_WIN_HI) ? ACC_WIN_HI : v;
    return 16'(v);
  endfunction : accExp
  task automatic trim(input logic [CAL_AW-1:0] a, input logic [CAL_DW-1:0] d);
    trimWrAddr = a;
    trimWrData = d;
    trimWrEn = 1'b1;
    @(negedge clk_sys);
    trimWrEn = 1'b0;
  endtask : trim
  // Select stays high long enough for reloads before each read
  task automatic rd(input logic [7:0] cmd, input int n);
    repeat (3 * LOAD) @(negedge clk_sys);
    u_incl_spi_host.xfer(cmd, n, rx);
  endtask : rd
  task automatic t_accel();
    int mgs [6] = '{0, 87, -87, 17, 2000, -2000};
    for (int w = 0; w < 2; w++) begin
      foreach (mgs[i]) begin
        rangeWide = w[0];
        accelMilliG = 16'(mgs[i]);
        rd(X_ACCEL_READ_CMD, ACC_W);
        chk(rx, accExp(mgs[i], w[0]), "accel code");
      end
    end
    rangeWide = 1'b0;
    accelMilliG = '0;
  endtask : t_accel
  task automatic t_temp();
    int ts [4] = '{25, 0, -60, 127};
    int v;
    foreach (ts[i]) begin
      tempCelsius = 8'(ts[i]);
      rd(TEMP_READ_CMD, TEMP_W);
      v = TEMP_OFFS - ts[i] * TEMP_SLOPE_MILLI / MILLI;
      v = (v < 0) ? 0 : (v > TEMP_MAX) ? TEMP_MAX : v;
      chk(rx, 16'(v), "temperature");
    end
  endtask : t_temp
  task automatic t_invalid();
    logic [7:0] bad [2] = '{8'h0f, 8'h11};
    foreach (bad[i]) begin
      u_incl_spi_host.sawOe = 1'b0;
      rd(bad[i], ACC_W);
      chk(16'(u_incl_spi_host.sawOe), 16'h0000, "invalid command drove data");
    end
  endtask : t_invalid
  task automatic t_fault();
    interconnectFail = 1'b1;
    rd(X_ACCEL_READ_CMD, ACC_W);
    chk(rx, 16'(ACC_FAULT), "interconnect fault code");
    interconnectFail = 1'b0;
    rd(X_ACCEL_READ_CMD, ACC_W);
    chk(rx, 16'h0400, "code after fault cleared");
  endtask : t_fault
  task automatic t_selftest();
    u_incl_spi_host.xfer(X_SELF_TEST_CMD, 0, rx);
    chk(16'(selfTestOn), 16'h0001, "serial self-test");
    repeat (SAT) @(negedge clk_sys);
    rd(X_ACCEL_READ_CMD, ACC_W);
    chk(rx, 16'(ACC_FULL), "serial self-test code");
    chk(16'(selfTestOn), 16'h0001, "latch kept over reads");
    u_incl_spi_host.xfer(MEASURE_MODE_CMD, 0, rx);
    chk(16'(selfTestOn), 16'h0000, "measure mode exit");
    repeat (REC) @(negedge clk_sys);
    rd(X_ACCEL_READ_CMD, ACC_W);
    chk(rx, 16'h0400, "code after recovery");
  endtask : t_selftest
  task automatic t_pin();
    selfTestPin = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(16'(selfTestOn), 16'h0001, "pin self-test");
    repeat (SAT) @(negedge clk_sys);
    rd(X_ACCEL_READ_CMD, ACC_W);
    chk(rx, 16'(ACC_FULL), "pin self-test code");
    selfTestPin = 1'b0;
    repeat (REC) @(negedge clk_sys);
    rd(X_ACCEL_READ_CMD, ACC_W);
    chk(rx, 16'h0400, "code after pin release");
  endtask : t_pin
  task automatic t_parity();
    sawReload = 1'b0;
    trim(3'h3, 9'h001); // One set bit breaks even parity
    repeat (100) @(negedge clk_sys);
    chk(16'(sawReload), 16'h0001, "reload walk");
    chk(16'(calFault), 16'h0000, "repaired by reload");
    nvmImage[3] = 9'h001;
    trim(3'h3, 9'h001);
    repeat (100) @(negedge clk_sys);
    chk(16'(calFault), 16'h0001, "fault after bad reload");
    rd(X_ACCEL_READ_CMD, ACC_W);
    chk(rx, 16'(ACC_FAULT), "code forced low");
  endtask : t_parity
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    {selfTestPin, rangeWide, interconnectFail, trimWrEn, sawReload} = '0;
    {accelMilliG, tempCelsius, trimWrAddr, trimWrData, nvmRdData} = '0;
    foreach (nvmImage[i]) nvmImage[i] = '0;
    @(negedge clk_sys);
    // Good-parity trim words while reset holds for ten cycles
    // Strobe stays up across the burst so it never toggles within one time step
    trimWrEn = 1'b1;
    for (int i = 0; i < CAL_WORDS; i++) begin
      trimWrAddr = CAL_AW'(i);
      @(negedge clk_sys);
    end
    trimWrEn = 1'b0;
    @(negedge clk_sys);
    reset_n = 1'b1;
    t_accel();
    t_temp();
    t_invalid();
    t_fault();
    t_selftest();
    t_pin();
    t_parity();
    results();
  end
  // Watchdog well beyond the expected run of some 6100 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    results();
  end
endmodule : incl_readout_tb_top
